// *** rtl/ttc_top.sv ***
// Thermal throttle controller: trip, gating and operating-point arbitration
//
// Behaviour
// - With an automatic mode enabled, a temperature trip activates the control circuit.
// - Trip threshold is fixed; no input can move it.
// - Snooping continues; interrupts are latched and serviced only while clocks run.
// - Temperature is reduced by clock gating or by stepping to a lower point.
// - Automatic and on-demand activation both exist; automatic wins when both apply.
// - Software enable bits choose the gating or stepping automatic mode.
// - Stepping mode under high temperature requests a lower operating point.
// - After cooling, request the point software last asked for before the event.
// - With both enables set, stepping is applied first.
// - If stepping fails to cool, gating is added while stepping stays.
// - A software request above the thermal target is deferred until event end.
// - A software request below the thermal target is applied at once.
// - Automatic gating runs a fixed half on, half off duty.
// - On-demand bit gates clocks at once with a three-bit eighths duty.
// - Hysteresis stops rapid toggling of the control circuit near the trip.
// - The active-low hot output asserts while the trip is detected.
`timescale 1ns/1ps
module ttc_top (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       temp_trip,
  input  wire ttc_pkg::ttc_cfg_type       cfg,
  input  wire ttc_pkg::ttc_req_type       sw_req,
  input  wire logic                       pt_done,
  input  wire logic                       irq_in,
  input  wire logic                       irq_ack,
  input  wire logic                       snoop_in,
  output logic                            die_hot_indicator_n,
  output logic                            thermal_control_circuit,
  output logic                            core_clk_en,
  output logic                            pt_req_valid,
  output logic [ttc_pkg::PT_W-1:0]        pt_req_point,
  output logic                            irq_pending,
  output logic                            irq_service,
  output logic                            snoop_out,
  output logic                            step_active
);

  // ----------------------------------------------------------------
  // Hot detection with hysteresis
  // ----------------------------------------------------------------
  // Threshold lives in the sensor; only its trip is seen here
  logic       hot_q;
  logic [7:0] hyst_q;
  wire        hyst_done = (hyst_q == ttc_pkg::HYST_CYC);
  wire        hot_d     = temp_trip ? 1'b1 : (hot_q && !hyst_done);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hot_q  <= 1'b0;
      hyst_q <= 8'h00;
    end else begin
      hot_q  <= hot_d;
      hyst_q <= (temp_trip || !hot_q) ? 8'h00 : hyst_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Stepping state machine
  // ----------------------------------------------------------------
  ttc_pkg::ttc_state_type state_q;
  ttc_pkg::ttc_state_type state_d;
  logic [ttc_pkg::PT_W-1:0] last_q;
  logic [ttc_pkg::PT_W-1:0] defer_pt_q;
  logic                     defer_q;
  logic                     req_v_q;
  logic [ttc_pkg::PT_W-1:0] req_pt_q;
  logic                     step_fail_q;

  wire step_mode  = cfg.auto_step_en;
  wire gate_mode  = cfg.auto_gate_en;
  wire auto_on    = step_mode || gate_mode;
  wire in_event   = (state_q != ttc_pkg::ST_IDLE);
  wire sw_higher  = sw_req.valid && (sw_req.point > ttc_pkg::THERMAL_PT);
  wire sw_lower   = sw_req.valid && !sw_higher;
  wire start_step = (state_q == ttc_pkg::ST_IDLE) && hot_q && step_mode;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ttc_pkg::ST_IDLE:    if (start_step) state_d = ttc_pkg::ST_STEP;
      ttc_pkg::ST_STEP:    if (!hot_q) state_d = ttc_pkg::ST_RESTORE;
      ttc_pkg::ST_RESTORE: state_d = ttc_pkg::ST_WAIT;
      ttc_pkg::ST_WAIT:    if (pt_done) state_d = ttc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ttc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Last point software asked for before the event; event requests never restore
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_q <= ttc_pkg::RST_PT;
    end else if (sw_req.valid && !in_event) begin
      last_q <= sw_req.point;
    end
  end

  // Deferred higher request; new defer beats release in the same cycle
  wire release_defer = (state_q == ttc_pkg::ST_WAIT) && pt_done;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      defer_q    <= 1'b0;
      defer_pt_q <= ttc_pkg::RST_PT;
    end else if (in_event && sw_higher) begin
      defer_q    <= 1'b1;
      defer_pt_q <= sw_req.point;
    end else if (release_defer || (in_event && sw_lower)) begin
      defer_q    <= 1'b0;
    end
  end

  // Request output mux
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_v_q  <= 1'b0;
      req_pt_q <= ttc_pkg::RST_PT;
    end else if (start_step) begin
      req_v_q  <= 1'b1;
      req_pt_q <= ttc_pkg::THERMAL_PT;
    end else if (state_q == ttc_pkg::ST_RESTORE) begin
      req_v_q  <= 1'b1;
      req_pt_q <= last_q;
    end else if (release_defer && defer_q) begin
      req_v_q  <= 1'b1;
      req_pt_q <= defer_pt_q;
    end else if (sw_req.valid && (!in_event || sw_lower)) begin
      req_v_q  <= 1'b1;
      req_pt_q <= sw_req.point;
    end else begin
      req_v_q  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Gating arbitration
  // ----------------------------------------------------------------
  // Gating is added only once a step has landed and the die is still hot
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      step_fail_q <= 1'b0;
    end else if (state_q != ttc_pkg::ST_STEP) begin
      step_fail_q <= 1'b0;
    end else if (temp_trip && pt_done) begin
      step_fail_q <= 1'b1;
    end
  end

  wire auto_gate = hot_q && gate_mode && (!step_mode || step_fail_q);
  wire gate_en   = auto_gate || cfg.demand_en;
  wire [ttc_pkg::DUTY_W-1:0] duty_sel = auto_gate ? ttc_pkg::AUTO_DUTY
                                                  : cfg.demand_duty;
  wire tcc_d     = (hot_d && auto_on) || cfg.demand_en;
  wire clk_run;

  ttc_gate i_ttc_gate (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .enable  (gate_en),
    .duty    (duty_sel),
    .clk_run (clk_run)
  );

  // ----------------------------------------------------------------
  // Interrupt latch and snoop path
  // ----------------------------------------------------------------
  // Ack wins only when no new request arrives that cycle
  logic irq_q;
  wire  irq_d = irq_in || (irq_q && !(irq_ack && clk_run));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q                   <= 1'b0;
      irq_service             <= 1'b0;
      snoop_out               <= 1'b0;
      core_clk_en             <= 1'b1;
      die_hot_indicator_n     <= 1'b1;
      thermal_control_circuit <= 1'b0;
      step_active             <= 1'b0;
    end else begin
      irq_q                   <= irq_d;
      irq_service             <= irq_q && clk_run;
      snoop_out               <= snoop_in;
      core_clk_en             <= clk_run;
      die_hot_indicator_n     <= !hot_d;
      thermal_control_circuit <= tcc_d;
      step_active             <= state_d != ttc_pkg::ST_IDLE;
    end
  end

  assign irq_pending  = irq_q;
  assign pt_req_valid = req_v_q;
  assign pt_req_point = req_pt_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_hot_pin_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
    temp_trip |=> !die_hot_indicator_n) else $error("hot output not asserted on trip");

  a_tcc_on_trip: assert property (@(posedge sys_clk) disable iff (!resetn)
    (temp_trip && auto_on) |=> thermal_control_circuit)
    else $error("control circuit idle on trip");

  a_demand_gates: assert property (@(posedge sys_clk) disable iff (!resetn)
    cfg.demand_en |=> thermal_control_circuit) else $error("demand did not activate");

  a_step_first: assert property (@(posedge sys_clk) disable iff (!resetn)
    (gate_mode && step_mode && !step_fail_q && !cfg.demand_en) |=> core_clk_en)
    else $error("gating before stepping");

  a_step_request: assert property (@(posedge sys_clk) disable iff (!resetn)
    start_step |=> (pt_req_valid && pt_req_point == ttc_pkg::THERMAL_PT))
    else $error("no lower point request");

  a_restore_last: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == ttc_pkg::ST_RESTORE && !sw_req.valid)
    |=> (pt_req_valid && pt_req_point == $past(last_q)))
    else $error("restore point wrong");

  a_defer_high: assert property (@(posedge sys_clk) disable iff (!resetn)
    (in_event && sw_higher && !start_step && state_q != ttc_pkg::ST_RESTORE && !release_defer)
    |=> !pt_req_valid) else $error("higher request not deferred");

  a_lower_now: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_q == ttc_pkg::ST_STEP && sw_lower)
    |=> (pt_req_valid && pt_req_point == $past(sw_req.point)))
    else $error("lower request not applied");

  a_hyst_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($fell(temp_trip) && hot_q) |=> hot_q [*8]) else $error("hot dropped without hysteresis");

  a_irq_latched: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq_in |=> irq_pending) else $error("interrupt not latched");

endmodule

// *** rtl/ttc_pkg.sv ***
// Package: constants and carrier types of the thermal throttle controller
package ttc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PT_W   = 4;
  localparam int unsigned DUTY_W = 3;

  // ----------------------------------------------------------------
  // Clock gating timing
  // ----------------------------------------------------------------
  // Core clock period in ns, and one gating slot in ns
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SLOT_NS       = 200;
  localparam int unsigned SLOT_CYC      = (SLOT_NS / CLK_PERIOD_NS) > 0 ?
                                          (SLOT_NS / CLK_PERIOD_NS) : 1;
  localparam logic [7:0]  SLOT_CYC_W    = SLOT_CYC[7:0];
  // Eight slots per gating period; automatic duty is four of eight on
  localparam logic [DUTY_W-1:0] AUTO_DUTY = 3'h4;

  // ----------------------------------------------------------------
  // Hysteresis and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]      HYST_CYC      = 8'h10;
  localparam logic [PT_W-1:0] THERMAL_PT    = 4'h0;
  localparam logic [PT_W-1:0] RST_PT        = 4'hf;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic            auto_gate_en;
    logic            auto_step_en;
    logic            demand_en;
    logic [DUTY_W-1:0] demand_duty;
  } ttc_cfg_type;

  typedef struct packed {
    logic            valid;
    logic [PT_W-1:0] point;
  } ttc_req_type;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_STEP    = 4'b0010,
    ST_RESTORE = 4'b0100,
    ST_WAIT    = 4'b1000
  } ttc_state_type;

endpackage

// *** rtl/ttc_gate.sv ***
// Clock gating duty generator: eight slots, duty slots on
`timescale 1ns/1ps
module ttc_gate (
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic                        enable,
  input  wire logic [ttc_pkg::DUTY_W-1:0]  duty,
  output logic                             clk_run
);

  // ----------------------------------------------------------------
  // Slot divider
  // ----------------------------------------------------------------
  logic [7:0]                    div_q;
  logic [ttc_pkg::DUTY_W-1:0]    slot_q;
  wire                           slot_tick = (div_q == ttc_pkg::SLOT_CYC_W - 8'h01);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_q  <= 8'h00;
      slot_q <= 3'h0;
    end else if (!enable) begin
      div_q  <= 8'h00;
      slot_q <= 3'h0;
    end else if (slot_tick) begin
      div_q  <= 8'h00;
      slot_q <= slot_q + 3'h1;
    end else begin
      div_q  <= div_q + 8'h01;
    end
  end

  // Zero duty would stop the core for good, so it runs free
  assign clk_run = !enable || (duty == 3'h0) || (slot_q < duty);

endmodule

// *** tb/ttc_top_tb.sv ***
// Self-checking bench of the thermal throttle controller
`timescale 1ns/1ps
module ttc_top_tb;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                      sys_clk;
  logic                      resetn;
  logic                      temp_trip;
  ttc_pkg::ttc_cfg_type      cfg;
  ttc_pkg::ttc_req_type      sw_req;
  logic                      pt_done;
  logic                      irq_in;
  logic                      irq_ack;
  logic                      snoop_in;
  logic                      die_hot_indicator_n;
  logic                      thermal_control_circuit;
  logic                      core_clk_en;
  logic                      pt_req_valid;
  logic [ttc_pkg::PT_W-1:0]  pt_req_point;
  logic                      irq_pending;
  logic                      irq_service;
  logic                      snoop_out;
  logic                      step_active;
  int                        n_mismatch;
  int                        comparisons;
  int                        cycles;
  int                        n_on;

  ttc_top i_ttc_top (
    .sys_clk                 (sys_clk),
    .resetn                  (resetn),
    .temp_trip               (temp_trip),
    .cfg                     (cfg),
    .sw_req                  (sw_req),
    .pt_done                 (pt_done),
    .irq_in                  (irq_in),
    .irq_ack                 (irq_ack),
    .snoop_in                (snoop_in),
    .die_hot_indicator_n     (die_hot_indicator_n),
    .thermal_control_circuit (thermal_control_circuit),
    .core_clk_en             (core_clk_en),
    .pt_req_valid            (pt_req_valid),
    .pt_req_point            (pt_req_point),
    .irq_pending             (irq_pending),
    .irq_service             (irq_service),
    .snoop_out               (snoop_out),
    .step_active             (step_active)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inputs move 2 ns after the edge so no race with the design
  task automatic step(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #2;
    end
  endtask

  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) bad(m);
  endtask

  task automatic chk_pt(input logic [ttc_pkg::PT_W-1:0] got,
                        input logic [ttc_pkg::PT_W-1:0] exp);
    comparisons++;
    if (got !== exp) bad("wrong requested point");
  endtask

  task automatic chk_num(input int got, input int exp, input string m);
    comparisons++;
    if (got != exp) bad(m);
  endtask

  task automatic do_reset;
    resetn    = 1'b0;
    temp_trip = 1'b0;
    cfg       = '0;
    sw_req    = '0;
    pt_done   = 1'b0;
    irq_in    = 1'b0;
    irq_ack   = 1'b0;
    snoop_in  = 1'b0;
    step(12);
    resetn = 1'b1;
    step(1);
  endtask

  task automatic pulse_done;
    pt_done = 1'b1;
    step(1);
    pt_done = 1'b0;
  endtask

  task automatic send_req(input logic [ttc_pkg::PT_W-1:0] p);
    sw_req = '{valid: 1'b1, point: p};
    step(1);
    sw_req = '0;
  endtask

  // Request pulse lasts one cycle, so it is sampled every cycle
  task automatic wait_req(input int lim);
    int i;
    i = 0;
    while (pt_req_valid !== 1'b1 && i < lim) begin
      step(1);
      i++;
    end
    chk_bit(pt_req_valid, 1'b1, "no point request");
  endtask

  // One gating period is 64 cycles, so any window of 64 gives the duty
  task automatic count_on;
    n_on = 0;
    repeat (64) begin
      step(1);
      if (core_clk_en === 1'b1) n_on++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    do_reset();
    chk_bit(die_hot_indicator_n, 1'b1, "hot after reset");
    chk_bit(thermal_control_circuit, 1'b0, "active after reset");
    chk_bit(core_clk_en, 1'b1, "clocks stopped after reset");
    chk_bit(pt_req_valid, 1'b0, "request after reset");
    chk_pt(pt_req_point, ttc_pkg::RST_PT);
    chk_bit(irq_pending, 1'b0, "irq after reset");
    chk_bit(step_active, 1'b0, "stepping after reset");
    $display("test reset done");
  endtask

  task automatic t_step;
    do_reset();
    cfg.auto_step_en = 1'b1;
    cfg.auto_gate_en = 1'b1;
    send_req(4'h9);
    wait_req(4);
    chk_pt(pt_req_point, 4'h9);
    pulse_done();
    step(20);
    chk_bit(thermal_control_circuit, 1'b0, "active while cool");
    temp_trip = 1'b1;
    step(2);
    chk_bit(die_hot_indicator_n, 1'b0, "hot not shown");
    chk_bit(thermal_control_circuit, 1'b1, "not active on trip");
    wait_req(6);
    chk_pt(pt_req_point, ttc_pkg::THERMAL_PT);
    count_on();
    chk_num(n_on, 64, "gating before stepping failed");
    send_req(4'h0);
    chk_bit(pt_req_valid, 1'b1, "lower request held");
    chk_pt(pt_req_point, 4'h0);
    send_req(4'h5);
    chk_bit(pt_req_valid, 1'b0, "higher request not deferred");
    // Still hot when the step lands: stepping was not enough
    pulse_done();
    step(16);
    count_on();
    chk_num(n_on, 32, "no gating added");
    chk_bit(step_active, 1'b1, "stepping dropped");
    temp_trip = 1'b0;
    step(8);
    chk_bit(die_hot_indicator_n, 1'b0, "no hysteresis");
    wait_req(40);
    chk_pt(pt_req_point, 4'h9);
    step(3);
    pulse_done();
    wait_req(8);
    chk_pt(pt_req_point, 4'h5);
    chk_bit(step_active, 1'b0, "event not ended");
    $display("test step done");
  endtask

  task automatic t_gate;
    int i;
    do_reset();
    cfg.auto_gate_en = 1'b1;
    temp_trip = 1'b1;
    step(16);
    chk_bit(thermal_control_circuit, 1'b1, "gating mode idle");
    count_on();
    chk_num(n_on, 32, "auto duty");
    cfg.demand_en   = 1'b1;
    cfg.demand_duty = 3'h1;
    step(16);
    count_on();
    chk_num(n_on, 32, "demand overrode auto");
    irq_in   = 1'b1;
    snoop_in = 1'b1;
    step(1);
    irq_in = 1'b0;
    chk_bit(snoop_out, 1'b1, "snoop lost");
    step(1);
    chk_bit(irq_pending, 1'b1, "irq not latched");
    i = 0;
    while (irq_service !== 1'b1 && i < 64) begin
      step(1);
      i++;
    end
    chk_bit(irq_service, 1'b1, "irq never serviced");
    // Ack is held until taken, as it only counts while clocks run
    irq_ack = 1'b1;
    i = 0;
    while (irq_pending !== 1'b0 && i < 64) begin
      step(1);
      i++;
    end
    irq_ack = 1'b0;
    chk_bit(irq_pending, 1'b0, "irq not cleared");
    $display("test gate done");
  endtask

  task automatic t_demand;
    do_reset();
    cfg.demand_en = 1'b1;
    for (int d = 0; d < 8; d++) begin
      cfg.demand_duty = d[2:0];
      step(16);
      count_on();
      chk_num(n_on, (d == 0) ? 64 : 8 * d, "demand duty");
    end
    chk_bit(thermal_control_circuit, 1'b1, "demand not active");
    $display("test demand done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs about 1100 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad("timeout");
      report_and_stop();
    end
  end

  initial begin
    n_mismatch  = 0;
    comparisons = 0;
    cycles      = 0;
    t_reset();
    t_step();
    t_gate();
    t_demand();
    report_and_stop();
  end

endmodule
